// [hdl/step_option_consts.svh]
// Constants for the step option decoder and trigger routing
`ifndef STEP_OPTION_CONSTS_SVH
`define STEP_OPTION_CONSTS_SVH
`define CMD_WAIT_RISE 4'h4
`define CMD_WAIT_FALL 4'h5
`define CMD_IRQ 4'h7
`define CMD_TRIG_HI 3'h4
`define IRQ_LAST_OPT 4'h7
`define IRQ_COUNT 8
`define TRIG_IN_COUNT 16
`define TRIG_OUT_COUNT 32
`define OUT_ADC_TRG30 5'h0C
`define OUT_REMAP_OUT46 5'h18
`define OUT_REMAP_OUT47 5'h19
`define OUT_REMAP_IN6 5'h1A
`define OUT_REMAP_IN7 5'h1B
`define IN_RESERVED_MASK 16'h4070
`endif

// [hdl/step_option_pkg.sv]
// Types for the step option decoder
package step_option_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } wait_state_t;
  typedef logic [7:0] step_byte_t;
endpackage

// [hdl/trigger_input_sync.sv]
// Two-flop synchroniser and edge detector for the trigger inputs
`timescale 1ns/1ps
`default_nettype none
`include "step_option_consts.svh"
module trigger_input_sync (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Raw trigger inputs
  input wire logic [`TRIG_IN_COUNT-1:0] raw_in,
  // Edge events
  trig_edge_if.producer edges
);
  logic [`TRIG_IN_COUNT-1:0] meta, sync, prev;
  logic [`TRIG_IN_COUNT-1:0] next_meta, next_sync, next_prev;

  always_comb begin
    next_meta = clk_en ? raw_in : meta;
    next_sync = clk_en ? meta : sync;
    next_prev = clk_en ? sync : prev;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 16'h0000;
      sync <= 16'h0000;
      prev <= 16'h0000;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign edges.rise = sync & ~prev;
  assign edges.fall = ~sync & prev;
endmodule
`default_nettype wire

// [hdl/trig_edge_if.sv]
// Edge events passed from the synchroniser to the decoder
`timescale 1ns/1ps
`default_nettype none
`include "step_option_consts.svh"
interface trig_edge_if;
  logic [`TRIG_IN_COUNT-1:0] rise;
  logic [`TRIG_IN_COUNT-1:0] fall;
  modport producer (output rise, output fall);
  modport consumer (input rise, input fall);
endinterface
`default_nettype wire

// [hdl/step_option_decode.sv]
// Step option decoder and trigger routing
// Notes on behaviour
// - Wait-for-rising and wait-for-falling steps use the option as an input index 0..15.
// - Interrupt steps with options 0..7 raise sequencer interrupt 0..7.
// - Reserved commands and interrupt options 8..15 complete as a step with no other effect; a wait on reserved input 4-6 or 14 never ends.
// - Trigger steps use the low command bit and option as an output index 0..31.
// - Inputs 0-3 come from PWM channels 1-4 and 9-11 from comparators 1-3.
// - Input 7 single capture 4, 8 multi capture 5, 12 logic cell, 13 ADC, 15 ext int 2.
`timescale 1ns/1ps
`default_nettype none
`include "step_option_consts.svh"
module step_option_decode
  import step_option_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Step command from the sequencer core
  input wire step_option_pkg::step_byte_t step_cmd,
  input wire logic step_valid,
  output logic step_done,
  // Peripheral trigger sources
  input wire logic [3:0] pwm_trigger,
  input wire logic single_capture_compare_4,
  input wire logic multi_capture_compare_5,
  input wire logic [2:0] comparator_trigger,
  input wire logic logic_cell_1,
  input wire logic adc_common_irq,
  input wire logic external_interrupt_2,
  // Sequencer interrupts, one-cycle pulses
  output logic [`IRQ_COUNT-1:0] seq_irq,
  // Routed trigger outputs, one-cycle pulses
  output logic adc_trigger_source_30,
  output logic remap_pin_46,
  output logic remap_pin_47,
  output logic remap_in_6,
  output logic remap_in_7,
  // Waiting indication
  output logic waiting
);
  import step_option_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger input map
  logic [`TRIG_IN_COUNT-1:0] trigger_input_n;
  always_comb begin
    trigger_input_n = 16'h0000;
    trigger_input_n[3:0] = pwm_trigger;
    trigger_input_n[7] = single_capture_compare_4;
    trigger_input_n[8] = multi_capture_compare_5;
    trigger_input_n[11:9] = comparator_trigger;
    trigger_input_n[12] = logic_cell_1;
    trigger_input_n[13] = adc_common_irq;
    trigger_input_n[15] = external_interrupt_2;
    trigger_input_n = trigger_input_n & ~`IN_RESERVED_MASK;
  end

  trig_edge_if edge_bus ();
  trigger_input_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .raw_in(trigger_input_n),
    .edges(edge_bus.producer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Step decode helpers
  function automatic logic [`TRIG_OUT_COUNT-1:0] one_hot32(
    input logic [4:0] idx);
    one_hot32 = 32'h0000_0001 << idx;
  endfunction

  function automatic logic is_wait_cmd(input logic [3:0] c);
    is_wait_cmd = (c == `CMD_WAIT_RISE) || (c == `CMD_WAIT_FALL);
  endfunction

  function automatic logic is_irq_cmd(input logic [3:0] c);
    is_irq_cmd = (c == `CMD_IRQ);
  endfunction

  function automatic logic is_trig_cmd(input logic [3:0] c);
    is_trig_cmd = (c[3:1] == `CMD_TRIG_HI);
  endfunction

  // Options above the last interrupt decode to nothing
  function automatic logic [`IRQ_COUNT-1:0] irq_one_hot(
    input logic [3:0] o);
    if (o <= `IRQ_LAST_OPT)
      irq_one_hot = 8'h01 << o[2:0];
    else
      irq_one_hot = 8'h00;
  endfunction

  function automatic logic pick_edge(
    input logic [`TRIG_IN_COUNT-1:0] rise_vec,
    input logic [`TRIG_IN_COUNT-1:0] fall_vec,
    input logic [3:0] sel,
    input logic want_rise);
    pick_edge = want_rise ? rise_vec[sel] : fall_vec[sel];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wait state machine
  wait_state_t state, next_state;
  logic wait_rise, next_wait_rise;
  logic [3:0] wait_sel, next_wait_sel;
  logic next_waiting;
  logic edge_hit;
  logic take;
  logic [3:0] cmd;
  logic [3:0] opt;

  assign cmd = step_cmd[7:4];
  assign opt = step_cmd[3:0];
  // Steps offered while a wait is pending are ignored
  assign take = step_valid && (state == ST_IDLE);

  // Only edges seen after entry count, so a stale edge cannot end a wait
  always_comb begin
    next_state = state;
    next_wait_rise = wait_rise;
    next_wait_sel = wait_sel;
    edge_hit = pick_edge(edge_bus.rise, edge_bus.fall, wait_sel,
                         wait_rise);
    unique case (state)
      ST_IDLE: begin
        if (take && is_wait_cmd(cmd)) begin
          next_wait_sel = opt;
          next_wait_rise = (cmd == `CMD_WAIT_RISE);
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (edge_hit)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    next_waiting = (next_state == ST_WAIT);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      wait_rise <= 1'b0;
      wait_sel <= 4'h0;
      waiting <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      wait_rise <= next_wait_rise;
      wait_sel <= next_wait_sel;
      waiting <= next_waiting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion and output pulses
  logic next_step_done;
  logic [`IRQ_COUNT-1:0] next_seq_irq;
  logic [`TRIG_OUT_COUNT-1:0] trig_out, next_trig_out;

  // Every step retires with one done pulse, reserved commands included, except a wait on a reserved input
  always_comb begin
    next_step_done = 1'b0;
    next_seq_irq = 8'h00;
    next_trig_out = 32'h0000_0000;
    if (state == ST_WAIT) begin
      next_step_done = edge_hit;
    end else if (take) begin
      if (is_irq_cmd(cmd)) begin
        next_seq_irq = irq_one_hot(opt);
        next_step_done = 1'b1;
      end else if (is_trig_cmd(cmd)) begin
        next_trig_out = one_hot32({cmd[0], opt});
        next_step_done = 1'b1;
      end else if (!is_wait_cmd(cmd)) begin
        next_step_done = 1'b1;
      end
    end
  end

  // Pulses hold while frozen and clear on the next enabled edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_done <= 1'b0;
      seq_irq <= 8'h00;
      trig_out <= 32'h0000_0000;
    end else if (clk_en) begin
      step_done <= next_step_done;
      seq_irq <= next_seq_irq;
      trig_out <= next_trig_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output routing, remaining outputs unconnected
  always_comb begin
    adc_trigger_source_30 = trig_out[`OUT_ADC_TRG30];
    remap_pin_46 = trig_out[`OUT_REMAP_OUT46];
    remap_pin_47 = trig_out[`OUT_REMAP_OUT47];
    remap_in_6 = trig_out[`OUT_REMAP_IN6];
    remap_in_7 = trig_out[`OUT_REMAP_IN7];
  end
endmodule
`default_nettype wire

// [sim/step_option_checker.sv]
// Port checker for the step option decoder
`timescale 1ns/1ps
`default_nettype none
module step_option_checker
  import step_option_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Step handshake
  input wire step_option_pkg::step_byte_t step_cmd,
  input wire logic step_valid,
  input wire logic step_done,
  input wire logic waiting,
  // Results
  input wire logic [7:0] seq_irq,
  input wire logic adc_trigger_source_30,
  input wire logic remap_pin_46,
  input wire logic remap_pin_47,
  input wire logic remap_in_6,
  input wire logic remap_in_7
);
  logic take;
  logic [4:0] tv;
  logic [4:0] ix;
  assign take = clk_en && step_valid && !waiting;
  assign tv = {remap_in_7, remap_in_6, remap_pin_47, remap_pin_46,
    adc_trigger_source_30};
  always_ff @(posedge clk) ix <= step_cmd[4:0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_wait; take && step_cmd[7:5] == 3'h2 |=> waiting; endproperty
  a_wait: assert property (p_wait) else $error("no wait");
  property p_wake; $fell(waiting) |-> step_done; endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_irq; take && step_cmd[7:3] == 5'h0E |=>
    step_done && seq_irq == 8'h01 << ix[2:0]; endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_nop; take && step_cmd[7:3] == 5'h0F |=>
    step_done && seq_irq == 8'h00 && tv == 5'h00; endproperty
  a_nop: assert property (p_nop) else $error("bad nop");
  property p_rsv; take && step_cmd[7:4] == 4'h6 |=> step_done && !waiting;
  endproperty
  a_rsv: assert property (p_rsv) else $error("bad rsv");
  property p_trig; take && step_cmd[7:5] == 3'h4 |=> step_done &&
    tv == {ix == 5'h1B, ix == 5'h1A, ix == 5'h19, ix == 5'h18, ix == 5'h0C};
  endproperty
  a_trig: assert property (p_trig) else $error("bad trig");
  property p_quiet; $past(clk_en) && !$past(take) |-> tv == 5'h00 &&
    seq_irq == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("stray pulse");
  c_irq: cover property (take ##1 seq_irq != 8'h00);
  c_adc: cover property (adc_trigger_source_30);
  c_wake: cover property ($fell(waiting));
endmodule
bind step_option_decode step_option_checker chk(.clk, .sys_rst, .clk_en,
  .step_cmd, .step_valid, .step_done, .waiting, .seq_irq,
  .adc_trigger_source_30, .remap_pin_46, .remap_pin_47, .remap_in_6,
  .remap_in_7);
`default_nettype wire

// [sim/peripheral_trigger_model.sv]
// Peripheral trigger sources feeding the decoder
`timescale 1ns/1ps
`default_nettype none
module peripheral_trigger_model (
  // Clock and wanted levels
  input wire logic clk,
  input wire logic [15:0] lvl,
  // Trigger lines
  output logic [3:0] pwm_trigger,
  output logic single_capture_compare_4,
  output logic multi_capture_compare_5,
  output logic [2:0] comparator_trigger,
  output logic logic_cell_1,
  output logic adc_common_irq,
  output logic external_interrupt_2
);
  // Lines 4 to 6 and 14 have no source
  always_ff @(posedge clk) begin
    pwm_trigger <= lvl[3:0];
    comparator_trigger <= lvl[11:9];
    single_capture_compare_4 <= lvl[7];
    multi_capture_compare_5 <= lvl[8];
    logic_cell_1 <= lvl[12];
    adc_common_irq <= lvl[13];
    external_interrupt_2 <= lvl[15];
  end
endmodule
`default_nettype wire

// [sim/step_option_decode_tb.sv]
// Self-checking bench for the step option decoder
`timescale 1ns/1ps
`default_nettype none
module step_option_decode_tb;
  import step_option_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, step_valid = 0;
  step_byte_t step_cmd = 8'h00;
  logic [15:0] lvl = 16'h0000;
  wire logic [7:0] seq_irq;
  wire logic [3:0] pwm_trigger;
  wire logic [2:0] comparator_trigger;
  wire logic step_done, waiting, adc_trigger_source_30, remap_pin_46,
    remap_pin_47, remap_in_6, remap_in_7, single_capture_compare_4,
    multi_capture_compare_5, logic_cell_1, adc_common_irq,
    external_interrupt_2;
  wire logic [13:0] obs = {seq_irq, remap_in_7, remap_in_6, remap_pin_47,
    remap_pin_46, adc_trigger_source_30, step_done};
  int fail_count = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  step_option_decode uut(.clk, .sys_rst, .clk_en, .step_cmd, .step_valid,
    .step_done, .pwm_trigger, .single_capture_compare_4,
    .multi_capture_compare_5, .comparator_trigger, .logic_cell_1,
    .adc_common_irq, .external_interrupt_2, .seq_irq, .adc_trigger_source_30,
    .remap_pin_46, .remap_pin_47, .remap_in_6, .remap_in_7, .waiting);
  peripheral_trigger_model far(.clk, .lvl, .pwm_trigger,
    .single_capture_compare_4, .multi_capture_compare_5, .comparator_trigger,
    .logic_cell_1, .adc_common_irq, .external_interrupt_2);
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk) sys_rst <= 1;
    repeat (10) @(posedge clk);
    sys_rst <= 0;
  endtask
  task automatic issue(input step_byte_t c);
    @(posedge clk) begin
      step_cmd <= c;
      step_valid <= 1;
    end
    @(posedge clk) step_valid <= 0;
    #1;
  endtask
  // Every non-wait step byte, with expected pulses
  task automatic t_steps;
    logic [13:0] e;
    for (int c = 0; c < 256; c++) begin
      if (c[7:5] == 3'h2) continue;
      e = 14'h0001;
      if (c[7:3] == 5'h0E) e[13:6] = 8'h01 << c[2:0];
      if (c[7:5] == 3'h4) e[5:1] = {c[4:0] == 5'h1B, c[4:0] == 5'h1A,
        c[4:0] == 5'h19, c[4:0] == 5'h18, c[4:0] == 5'h0C};
      issue(c[7:0]);
      chk(obs, e);
    end
  endtask
  // Rising then falling waits on every input
  task automatic t_wait;
    int n;
    logic m;
    logic [15:0] used;
    for (int i = 0; i < 32; i++) begin
      used = 16'hBF8F;
      m = used[i[3:0]];
      @(posedge clk) lvl[i[3:0]] <= i[4];
      repeat (5) @(posedge clk);
      issue({3'h2, i[4], i[3:0]});
      chk({13'h0000, waiting}, 14'h0001);
      issue(8'h70);
      chk(obs, 14'h0000);
      chk({13'h0000, waiting}, 14'h0001);
      @(posedge clk) lvl[i[3:0]] <= !i[4];
      n = 0;
      while (step_done !== 1'b1 && n < 10) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk({12'h000, waiting, step_done}, {12'h000, !m, m});
      if (!m) do_reset;
    end
  endtask
  // A step offered while frozen is taken only once the enable returns
  task automatic t_freeze;
    @(posedge clk) begin
      clk_en <= 0;
      step_cmd <= 8'h8C;
      step_valid <= 1;
    end
    repeat (3) @(posedge clk);
    #1;
    chk(obs, 14'h0000);
    @(posedge clk) clk_en <= 1;
    @(posedge clk) step_valid <= 0;
    #1;
    chk(obs, 14'h0003);
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  initial begin
    do_reset;
    t_steps;
    t_wait;
    t_freeze;
    end_sim;
  end
endmodule
`default_nettype wire
